// ===== src/pesh_pkg.sv
package pesh_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CSR = 8'h04;
   localparam logic [7:0] OFF_STAT_SET = 8'h10;
   localparam logic [7:0] OFF_STAT_CLR = 8'h14;
   localparam logic [7:0] OFF_HOST_IEN = 8'h18;
   localparam logic [7:0] OFF_DSP_IEN = 8'h1C;
   localparam logic [7:0] OFF_FAULT = 8'h20;

   // ------------------------------------------------------------
   // command/status register fields
   // ------------------------------------------------------------
   localparam int CSR_PAR_RESP = 6;
   localparam int CSR_SYSERR_PIN_ENABLE = 8;
   localparam int CSR_MPAR_REP = 24;
   localparam int CSR_SIG_TABORT = 27;
   localparam int CSR_RCV_TABORT = 28;
   localparam int CSR_RCV_MABORT = 29;
   localparam int CSR_SIG_SERR = 30;
   localparam int CSR_DET_PAR = 31;
   localparam logic [31:0] CSR_CTRL_MASK = 32'h0000_0140;
   localparam logic [31:0] CSR_STAT_MASK = 32'hF900_0000;
   localparam logic [31:0] CSR_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // internal status flags
   // ------------------------------------------------------------
   localparam int ST_SOFT = 0;
   localparam int ST_PERR = 1;
   localparam int ST_SERR = 2;
   localparam int ST_MABORT = 3;
   localparam int ST_TABORT = 4;
   localparam int ST_W = 5;
   localparam logic [4:0] ST_RESET = 5'h00;

   // ------------------------------------------------------------
   // timing: parity pin held for two clocks after the error cycle
   // ------------------------------------------------------------
   localparam logic [1:0] PERR_HOLD = 2'h2;

   // ------------------------------------------------------------
   // axi responses
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // bus events sampled from the transaction engines
   typedef struct packed {
      logic master_active;
      logic is_read;
      logic data_phase;
      logic data_par_err;
      logic addr_par_err;
      logic mabort;
      logic tabort_rcvd;
      logic tabort_sig;
      logic target_disc;
   } pesh_evt_t;

   // terminal controls returned to the master engine
   typedef struct packed {
      logic end_frame;
      logic force_irdy;
      logic local_ready;
      logic reissue;
      logic halt;
   } pesh_term_t;
endpackage

// ===== src/pesh_sync.sv
// two-flop synchroniser for pin levels
module pesh_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage read only by the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ===== src/pesh_top.sv
module pesh_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // host config cycles (pci clock domain, level-held)
   input wire logic cfg_wr_tog,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   // pci pins and link clock
   input wire logic pci_clk,
   input wire logic parity_error_pin_in,
   output logic parity_error_pin_out,
   output logic parity_error_pin_oe_n,
   output logic system_error_pin_out,
   output logic system_error_pin_oe_n,
   output logic host_interrupt_pin_out,
   output logic host_interrupt_pin_oe_n,
   // events from transaction engines
   input wire pesh_pkg::pesh_evt_t evt,
   input wire logic [1:0] master_addr_lo,
   // controls to the transaction engines
   output pesh_pkg::pesh_term_t term,
   output logic master_addr_fault,
   // dsp interrupt and events
   output logic dsp_irq,
   output logic parity_event,
   output logic syserr_event,
   output logic master_abort_event,
   output logic target_abort_event
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_s;
   logic [2:0] pin_raw;
   logic pclk_q;
   logic cfg_tog_q;
   logic pclk_rise;
   logic cfg_wr;
   logic perr_seen;
   logic [1:0] prime_q;

   assign pin_raw = {cfg_wr_tog, pci_clk, ~parity_error_pin_in};

   pesh_sync #(.W(3)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(pin_raw),
      .q(pin_s)
   );

   // edge detect on synchronised copies only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pclk_q <= 1'b0;
         cfg_tog_q <= 1'b0;
         prime_q <= 2'h0;
      end
      else
      begin
         pclk_q <= pin_s[1];
         cfg_tog_q <= pin_s[2];
         if (prime_q != 2'h3)
            prime_q <= prime_q + 2'h1;
      end
   end
   // no edges until the synchroniser holds real levels: a toggle line
   // left high across reset must not look like a config write
   assign pclk_rise = (prime_q == 2'h3) & pin_s[1] & ~pclk_q;
   assign cfg_wr = (prime_q == 2'h3) & (pin_s[2] ^ cfg_tog_q);
   assign perr_seen = pin_s[0];

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] csr_q;
   logic [4:0] st_q;
   logic [4:0] hien_q;
   logic [4:0] dien_q;
   logic sysflag_q;
   logic halt_q;
   logic [1:0] perr_cnt_q;
   logic perr_drv_q;
   logic serr_drv_q;

   // qualified bus events, sampled on pci clock edges
   logic m_rd_perr;
   logic m_wr_perr;
   logic t_wr_perr;
   logic a_perr;
   logic mabort;
   logic tabort;
   logic tsig;
   logic live;

   assign live = pclk_rise & ~halt_q;
   assign m_rd_perr = live & evt.master_active & evt.is_read
                      & evt.data_phase & evt.data_par_err;
   assign m_wr_perr = live & evt.master_active & ~evt.is_read
                      & evt.data_phase & perr_seen;
   assign t_wr_perr = live & ~evt.master_active & ~evt.is_read
                      & evt.data_phase & evt.data_par_err;
   assign a_perr = live & evt.addr_par_err;
   assign mabort = live & evt.master_active & evt.mabort;
   assign tabort = live & evt.master_active & evt.tabort_rcvd;
   assign tsig = live & ~evt.master_active & evt.tabort_sig;

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   logic [7:0] aw_q;
   logic aw_have_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   logic w_have_q;
   logic do_wr;
   logic [31:0] wmask;

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == pesh_pkg::OFF_CSR) || (a == pesh_pkg::OFF_STAT_SET)
               || (a == pesh_pkg::OFF_STAT_CLR)
               || (a == pesh_pkg::OFF_HOST_IEN)
               || (a == pesh_pkg::OFF_DSP_IEN)
               || (a == pesh_pkg::OFF_FAULT);
   endfunction

   assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wmask = strb_mask(ws_q) & w_q;

   // address and data taken independently, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pesh_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_have_q & ~s_axi_awready;
         s_axi_wready <= ~w_have_q & ~s_axi_wready;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_q <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_q) ? pesh_pkg::RESP_OKAY
                                        : pesh_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read channel, answer two cycles after address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pesh_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~s_axi_arvalid
                          ? 1'b0 : (~s_axi_rvalid & ~s_axi_arready);
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00})
                           ? pesh_pkg::RESP_OKAY : pesh_pkg::RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
               pesh_pkg::OFF_CSR: s_axi_rdata <= csr_q;
               pesh_pkg::OFF_STAT_SET,
               pesh_pkg::OFF_STAT_CLR: s_axi_rdata <= {27'h0, st_q};
               pesh_pkg::OFF_HOST_IEN: s_axi_rdata <= {27'h0, hien_q};
               pesh_pkg::OFF_DSP_IEN: s_axi_rdata <= {27'h0, dien_q};
               pesh_pkg::OFF_FAULT: s_axi_rdata <= {30'h0, sysflag_q, halt_q};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // command/status register, shared by host and mirror
   // ------------------------------------------------------------
   logic csr_wr;
   logic [31:0] csr_wv;
   logic [31:0] csr_set;

   // host config write wins over a simultaneous mirror write
   assign csr_wr = cfg_wr | (do_wr & (aw_q == pesh_pkg::OFF_CSR));
   assign csr_wv = cfg_wr ? cfg_wdata : wmask;

   always_comb
   begin
      csr_set = 32'h0000_0000;
      csr_set[pesh_pkg::CSR_MPAR_REP] = m_rd_perr | m_wr_perr;
      csr_set[pesh_pkg::CSR_DET_PAR] = m_rd_perr | t_wr_perr
                                       | a_perr;
      csr_set[pesh_pkg::CSR_RCV_MABORT] = mabort;
      csr_set[pesh_pkg::CSR_RCV_TABORT] = tabort;
      csr_set[pesh_pkg::CSR_SIG_TABORT] = tsig;
      csr_set[pesh_pkg::CSR_SIG_SERR] = serr_drv_q;
   end

   // write one clears status; set beats clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         csr_q <= pesh_pkg::CSR_RESET;
      else
      begin
         if (csr_wr)
            csr_q <= ((csr_q & ~(csr_wv & pesh_pkg::CSR_STAT_MASK)
                       & ~pesh_pkg::CSR_CTRL_MASK)
                      | (csr_wv & pesh_pkg::CSR_CTRL_MASK)
                      | csr_set);
         else
            csr_q <= csr_q | csr_set;
      end
   end
   assign cfg_rdata = csr_q;

   // ------------------------------------------------------------
   // internal status and enables
   // ------------------------------------------------------------
   logic [4:0] st_hw;
   logic [4:0] st_sw_set;
   logic [4:0] st_sw_clr;

   always_comb
   begin
      st_hw = 5'h00;
      st_hw[pesh_pkg::ST_PERR] = m_rd_perr | t_wr_perr;
      st_hw[pesh_pkg::ST_SERR] = tabort | a_perr;
      st_hw[pesh_pkg::ST_MABORT] = mabort;
      st_hw[pesh_pkg::ST_TABORT] = tsig;
      st_sw_set = (do_wr & (aw_q == pesh_pkg::OFF_STAT_SET))
                  ? wmask[4:0] : 5'h00;
      st_sw_clr = (do_wr & (aw_q == pesh_pkg::OFF_STAT_CLR))
                  ? wmask[4:0] : 5'h00;
   end

   // independent of the command/status bits; set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st_q <= pesh_pkg::ST_RESET;
      else
         st_q <= (st_q & ~st_sw_clr) | st_sw_set | st_hw;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hien_q <= 5'h00;
         dien_q <= 5'h00;
      end
      else
      begin
         if (do_wr & (aw_q == pesh_pkg::OFF_HOST_IEN))
            hien_q <= wmask[4:0];
         if (do_wr & (aw_q == pesh_pkg::OFF_DSP_IEN))
            dien_q <= wmask[4:0];
      end
   end

   // event pulses for the dsp side
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         parity_event <= 1'b0;
         syserr_event <= 1'b0;
         master_abort_event <= 1'b0;
         target_abort_event <= 1'b0;
      end
      else
      begin
         parity_event <= st_hw[pesh_pkg::ST_PERR];
         syserr_event <= st_hw[pesh_pkg::ST_SERR];
         master_abort_event <= mabort;
         target_abort_event <= tsig;
      end
   end

   // ------------------------------------------------------------
   // system error flag and halt
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sysflag_q <= 1'b0;
         halt_q <= 1'b0;
         serr_drv_q <= 1'b0;
      end
      else
      begin
         if ((a_perr & csr_q[pesh_pkg::CSR_PAR_RESP])
             | (live & evt.master_active & perr_seen) | tabort)
            sysflag_q <= 1'b1;
         serr_drv_q <= sysflag_q & csr_q[pesh_pkg::CSR_SYSERR_PIN_ENABLE];
         if (serr_drv_q)
            halt_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // parity pin drive: hold counts pci edges after the error cycle
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         perr_cnt_q <= 2'h0;
         perr_drv_q <= 1'b0;
      end
      else
      begin
         if ((m_rd_perr | t_wr_perr | a_perr)
             & csr_q[pesh_pkg::CSR_PAR_RESP])
         begin
            perr_cnt_q <= pesh_pkg::PERR_HOLD;
            perr_drv_q <= 1'b1;
         end
         else if (pclk_rise & (perr_cnt_q != 2'h0))
            perr_cnt_q <= perr_cnt_q - 2'h1;
         else if (pclk_rise)
            perr_drv_q <= 1'b0;
         // the detected flag may be set in this very cycle
         if (!(csr_q[pesh_pkg::CSR_PAR_RESP]
               & (csr_q[pesh_pkg::CSR_DET_PAR]
                  | csr_set[pesh_pkg::CSR_DET_PAR])))
            perr_drv_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // pins, interrupts and termination controls
   // ------------------------------------------------------------
   logic abort_q;

   // abort stays until the engine's transfer ends; parity never aborts
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         abort_q <= 1'b0;
      else if (mabort | tabort)
         abort_q <= 1'b1;
      else if (pclk_rise & ~evt.master_active)
         abort_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         parity_error_pin_out <= 1'b1;
         parity_error_pin_oe_n <= 1'b1;
         system_error_pin_out <= 1'b1;
         system_error_pin_oe_n <= 1'b1;
         host_interrupt_pin_out <= 1'b1;
         host_interrupt_pin_oe_n <= 1'b1;
         dsp_irq <= 1'b0;
         term <= '0;
         master_addr_fault <= 1'b0;
      end
      else
      begin
         parity_error_pin_out <= ~perr_drv_q;
         parity_error_pin_oe_n <= ~perr_drv_q;
         system_error_pin_out <= ~serr_drv_q;
         system_error_pin_oe_n <= ~serr_drv_q;
         host_interrupt_pin_out <= 1'b0;
         host_interrupt_pin_oe_n <= ~|(st_q & hien_q);
         dsp_irq <= |(st_q & dien_q);
         term.end_frame <= abort_q | halt_q;
         term.force_irdy <= abort_q;
         term.local_ready <= abort_q;
         // silent reissue; target disconnect also ends a parity case
         term.reissue <= evt.master_active & evt.target_disc
                         & ~abort_q & ~halt_q;
         term.halt <= halt_q;
         master_addr_fault <= evt.master_active
                              & (master_addr_lo != 2'b00);
      end
   end
endmodule

// ===== verification/pesh_sva.sv
module pesh_sva (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // watched ports
   input wire logic [31:0] cfg_rdata,
   input wire logic parity_error_pin_oe_n,
   input wire logic system_error_pin_oe_n,
   input wire pesh_pkg::pesh_evt_t evt,
   input wire logic [1:0] master_addr_lo,
   input wire pesh_pkg::pesh_term_t term,
   input wire logic master_addr_fault,
   input wire logic master_abort_event,
   input wire logic target_abort_event
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------
   // history
   // ------------
   // recent frame ends; the term level follows the event pulse by a cycle
   logic [3:0] ef_q;
   always_ff @(posedge aclk)
   begin
      ef_q <= {ef_q[2:0], term.end_frame};
   end
   a_perr_gate: assert property (
      $fell(parity_error_pin_oe_n) |->
      cfg_rdata[pesh_pkg::CSR_PAR_RESP] && cfg_rdata[pesh_pkg::CSR_DET_PAR])
      else $error("parity pin driven without enable and flag");
   a_perr_hold: assert property (
      $fell(parity_error_pin_oe_n) |-> !parity_error_pin_oe_n [*8])
      else $error("parity pin released too early");
   a_serr_gate: assert property (
      $fell(system_error_pin_oe_n) |-> cfg_rdata[pesh_pkg::CSR_SYSERR_PIN_ENABLE])
      else $error("system error pin driven while disabled");
   a_serr_flag: assert property (
      $fell(system_error_pin_oe_n) |->
      ##[0:3] cfg_rdata[pesh_pkg::CSR_SIG_SERR])
      else $error("signaled system error bit not set");
   a_halt_start: assert property (
      $fell(system_error_pin_oe_n) |-> ##[0:3] term.halt)
      else $error("no halt after system error pin");
   a_halt_sticky: assert property (
      term.halt |=> term.halt)
      else $error("halt dropped without reset");
   a_mabort_end: assert property (
      master_abort_event |-> ##[0:3] (ef_q != 4'h0))
      else $error("master abort without frame end");
   a_mabort_cause: assert property (
      master_abort_event |-> evt.master_active && evt.mabort)
      else $error("master abort event without master abort");
   a_tabort_cause: assert property (
      target_abort_event |-> evt.tabort_sig)
      else $error("target abort event without signaled abort");
   a_align_fault: assert property (
      (evt.master_active && master_addr_lo != 2'h0) [*4] |->
      ##[0:20] master_addr_fault)
      else $error("misaligned master start not flagged");
   a_reset_clear: assert property (
      $rose(aresetn) |->
      cfg_rdata == 32'h0000_0000 && system_error_pin_oe_n)
      else $error("status not cleared by reset");
endmodule

bind pesh_top pesh_sva pesh_sva_i (
   .aclk, .aresetn, .cfg_rdata, .parity_error_pin_oe_n,
   .system_error_pin_oe_n, .evt, .master_addr_lo, .term,
   .master_addr_fault, .master_abort_event, .target_abort_event);

// ===== verification/pesh_pci_agent.sv
module pesh_pci_agent (
   // bench clock
   input wire logic aclk,
   // far side of the bus
   output logic pci_clk,
   output pesh_pkg::pesh_evt_t evt,
   output logic [1:0] addr_lo,
   output logic perr_far_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // free running bus clock, phase unrelated to aclk
   initial
   begin
      pci_clk = 1'b0;
      evt = '0;
      addr_lo = 2'h0;
      perr_far_n = 1'b1;
      #37;
      forever #80 pci_clk = ~pci_clk;
   end
   // one data phase: levels held for a whole bus clock
   task automatic phase(input pesh_pkg::pesh_evt_t e, input logic p_n,
                        input logic [1:0] lo);
      @(negedge pci_clk);
      @(posedge aclk);
      evt <= e;
      addr_lo <= lo;
      perr_far_n <= p_n;
      @(negedge pci_clk);
      @(posedge aclk);
      evt <= '0;
      addr_lo <= ~lo; // no stale value once released
      perr_far_n <= 1'b1; // pull-up takes over
   endtask
endmodule

// ===== verification/tb_pci_error_status_handler.sv
`define CHK(g, e) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("wrong value at %0t: %h %h", $time, g, e); \
      end \
   end

module tb_pci_error_status_handler;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------
   // bench state
   // ------------
   localparam logic [1:0] OK = pesh_pkg::RESP_OKAY;
   localparam logic [1:0] BAD = pesh_pkg::RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed = 91;
   logic [31:0] csr_exp, rv;
   logic [33:0] er;
   logic [1:0] eb;
   logic [4:0] t_st[6] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h04, 5'h10};
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];
   logic [8:0] t_ev[6] = '{9'h140, 9'h1E0, 9'h010, 9'h108, 9'h104, 9'h002};
   logic [31:0] t_set[6] = '{32'h0100_0000, 32'h8100_0000, 32'h8000_0000,
                             32'h2000_0000, 32'h1000_0000, 32'h0800_0000};
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, cfg_wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, cfg_wr_tog = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, addr_lo;
   logic [31:0] rdata, cfg_rdata;
   logic pci_clk, perr_far_n, perr_in, perr_out, perr_oe_n;
   logic hint_oe_n, serr_oe_n, dsp_irq;
   pesh_pkg::pesh_evt_t evt;
   // wired-and parity line with pull-up
   assign perr_in = perr_far_n & (perr_oe_n | perr_out);
   always #5 aclk = ~aclk;

   pesh_top pesh_top_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cfg_wr_tog(cfg_wr_tog), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .pci_clk(pci_clk),
      .parity_error_pin_in(perr_in), .parity_error_pin_out(perr_out),
      .parity_error_pin_oe_n(perr_oe_n), .system_error_pin_out(),
      .system_error_pin_oe_n(serr_oe_n), .host_interrupt_pin_out(),
      .host_interrupt_pin_oe_n(hint_oe_n), .evt(evt),
      .master_addr_lo(addr_lo), .term(), .master_addr_fault(),
      .dsp_irq(dsp_irq), .parity_event(), .syserr_event(),
      .master_abort_event(), .target_abort_event());

   pesh_pci_agent pesh_pci_agent_i (
      .aclk(aclk), .pci_clk(pci_clk), .evt(evt), .addr_lo(addr_lo),
      .perr_far_n(perr_far_n));

   // scoreboard: every handshake retires the oldest note
   always @(posedge aclk)
   begin
      if (rvalid && rready && exp_r.size() > 0)
      begin
         er = exp_r.pop_front();
         `CHK({rresp, rdata}, er)
      end
      if (bvalid && bready && exp_b.size() > 0)
      begin
         eb = exp_b.pop_front();
         `CHK(bresp, eb)
      end
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   // both channels offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      exp_b.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [1:0] r,
                         input logic [31:0] d);
      exp_r.push_back({r, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // config write: data held well past the synchroniser
   task automatic cfg_wr(input logic [31:0] d);
      @(posedge aclk);
      cfg_wdata <= d;
      @(posedge aclk);
      cfg_wr_tog <= ~cfg_wr_tog;
      repeat (8) @(posedge aclk);
   endtask

   task automatic chk_csr();
      axi_rd(pesh_pkg::OFF_CSR, OK, csr_exp);
      `CHK(cfg_rdata, csr_exp)
   endtask

   task automatic ev(input logic [8:0] e, input logic p_n,
                     input logic [1:0] lo);
      pesh_pci_agent_i.phase(pesh_pkg::pesh_evt_t'(e), p_n, lo);
      repeat (40) @(posedge aclk);
   endtask

   initial
   begin
      do_reset();
      csr_exp = 32'h0000_0000;
      chk_csr();
      axi_rd(pesh_pkg::OFF_FAULT, OK, 32'h0000_0000);
      axi_rd(8'h3C, BAD, 32'h0000_0000);
      axi_wr(8'h3C, 32'hFFFF_FFFF, BAD);
      axi_wr(pesh_pkg::OFF_CSR, 32'hF900_0040, OK);
      csr_exp = 32'h0000_0040;
      chk_csr();
      $display("test registers done");
      rv = $random(seed);
      axi_wr(pesh_pkg::OFF_STAT_SET, rv & 32'h0000_001F, OK);
      axi_rd(pesh_pkg::OFF_STAT_SET, OK, rv & 32'h0000_001F);
      axi_wr(pesh_pkg::OFF_STAT_CLR, 32'h0000_0015, OK);
      axi_rd(pesh_pkg::OFF_STAT_CLR, OK, rv & 32'h0000_000A);
      chk_csr();
      axi_wr(pesh_pkg::OFF_STAT_CLR, 32'h0000_001F, OK);
      axi_wr(pesh_pkg::OFF_HOST_IEN, 32'h0000_0001, OK);
      axi_wr(pesh_pkg::OFF_STAT_SET, 32'h0000_0001, OK);
      repeat (4) @(posedge aclk);
      `CHK({hint_oe_n, dsp_irq}, 2'h0)
      axi_wr(pesh_pkg::OFF_DSP_IEN, 32'h0000_0001, OK);
      repeat (4) @(posedge aclk);
      `CHK({hint_oe_n, dsp_irq}, 2'h1)
      axi_wr(pesh_pkg::OFF_STAT_CLR, 32'h0000_0001, OK);
      repeat (4) @(posedge aclk);
      `CHK({hint_oe_n, dsp_irq}, 2'h2)
      $display("test internal status done");
      // each bus event sets exactly its own status bits
      for (int i = 0; i < 6; i++)
      begin
         axi_wr(pesh_pkg::OFF_STAT_CLR, 32'h0000_001F, OK);
         if (i[0])
            cfg_wr(32'hF900_0040);
         else
            axi_wr(pesh_pkg::OFF_CSR, 32'hF900_0040, OK);
         csr_exp = 32'h0000_0040;
         ev(t_ev[i], i != 0, 2'h0);
         csr_exp = csr_exp | t_set[i];
         chk_csr();
         axi_rd(pesh_pkg::OFF_STAT_SET, OK, {27'h0, t_st[i]});
      end
      axi_rd(pesh_pkg::OFF_FAULT, OK, 32'h0000_0002);
      ev(9'h100, 1'b1, 2'h2);
      $display("test bus events done");
      axi_wr(pesh_pkg::OFF_CSR, 32'h0000_0140, OK);
      repeat (8) @(posedge aclk);
      csr_exp = 32'h4800_0140;
      chk_csr();
      `CHK(serr_oe_n, 1'b0)
      axi_rd(pesh_pkg::OFF_FAULT, OK, 32'h0000_0003);
      do_reset();
      csr_exp = 32'h0000_0000;
      chk_csr();
      axi_rd(pesh_pkg::OFF_FAULT, OK, 32'h0000_0000);
      $display("test system error done");
      complete_run();
   end
endmodule
